//--- sar_adc_sequencer.sv
// sar_adc_sequencer: digital control of a 12-bit successive-approximation converter
// assumes a synchronous comparator input valid in the cycle a trial code is shown,
// and trigger pulses synchronous to ref_clk
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer
    import sar_pkg::*;
#(
    parameter logic [RES_W-1:0] CAL_TS_VAL  = 12'h5A5,  // arbitrary value
    parameter logic [RES_W-1:0] CAL_REF_VAL = 12'h6B6   // arbitrary value
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output var  logic [31:0]       readdata,
    output var  logic              waitrequest,
    // timer triggers
    input  wire logic              reg_trig,
    input  wire logic              inj_trig,
    // dma handshake
    output var  logic              dma_req,
    input  wire logic              dma_ack,
    // analog front end
    output var  ana_t              ana,
    input  wire logic              cmp_above,
    // interrupt
    output var  logic              irq
);

    regs_t st_ff;
    regs_t nxt_st;

    // ---------------------------------------------------------------
    // scan search: lowest masked channel above a start point
    // ---------------------------------------------------------------
    function automatic logic [CH_W:0] next_ch(input logic [NUM_CH-1:0] mask,
                                              input logic [CH_W-1:0]   cur,
                                              input logic              from_top);
        logic [CH_W:0] found;
        found = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && (from_top || i > int'(cur))) begin
                found = {1'b1, CH_W'(i)};
            end
        end
        return found;
    endfunction : next_ch

    // ---------------------------------------------------------------
    // per-channel watchdog scope
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] watched;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_scope
            always_comb begin
                unique case (st_ff.awd_mode)
                    AWD_ONE: watched[g] = (st_ff.awd_ch == CH_W'(g));
                    AWD_SUB: watched[g] = st_ff.awd_mask[g];
                    default: watched[g] = 1'b1;
                endcase
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [31:0] rmux;

    always_comb begin
        rmux = '0;
        unique case (address)
            OFS_CTRL: begin
                rmux[C_EN]                = st_ff.en;
                rmux[C_SCAN]              = st_ff.scan;
                rmux[C_RTRIG]             = st_ff.rtrig_en;
                rmux[C_JTRIG]             = st_ff.jtrig_en;
                rmux[C_AWD]               = st_ff.awd_en;
                rmux[C_AWDM+1:C_AWDM]     = st_ff.awd_mode;
                rmux[C_DMA]               = st_ff.dma_en;
            end
            OFS_CHSEL: begin
                rmux[CH_W-1:0]            = st_ff.sgl_ch;
                rmux[CHS_INJ+CH_W-1:CHS_INJ] = st_ff.inj_ch;
            end
            OFS_SCAN:  rmux[NUM_CH-1:0]   = st_ff.scan_mask;
            OFS_AWDCH: rmux[CH_W-1:0]     = st_ff.awd_ch;
            OFS_AWDMK: rmux[NUM_CH-1:0]   = st_ff.awd_mask;
            OFS_THR: begin
                rmux[RES_W-1:0]           = st_ff.thr_lo;
                rmux[THR_HI+RES_W-1:THR_HI] = st_ff.thr_hi;
            end
            OFS_DATA: begin
                rmux[RES_W-1:0]           = st_ff.rdata;
                rmux[DATA_CH+CH_W-1:DATA_CH] = st_ff.rch;
            end
            OFS_JDATA: rmux[RES_W-1:0]    = st_ff.jdata;
            OFS_STAT: begin
                rmux[NUM_EV-1:0]          = st_ff.status;
                rmux[ST_BUSY]             = (st_ff.phase != PH_IDLE) | st_ff.scan_act;
            end
            OFS_IEN:   rmux[NUM_EV-1:0]   = st_ff.ien;
            OFS_CALTS: rmux[RES_W-1:0]    = CAL_TS_VAL;
            OFS_CALRF: rmux[RES_W-1:0]    = CAL_REF_VAL;
            default:   rmux               = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    logic              acc, wr, rd;
    logic [NUM_EV-1:0] ev_set, ev_clr;
    logic [RES_W-1:0]  res;
    logic [CH_W:0]     nc;

    always_comb begin
        nxt_st = st_ff;
        ev_set = '0;
        ev_clr = '0;
        res    = '0;
        nc     = '0;

        // one wait cycle per access; the access completes on the edge after it
        // read data is latched at the accept edge so it stands through completion
        acc = !st_ff.waitreq && (read || write);
        wr  = acc && write;
        rd  = acc && read;
        if (st_ff.waitreq && (read || write)) begin
            nxt_st.waitreq = 1'b0;
            nxt_st.rd      = rmux;
        end else begin
            nxt_st.waitreq = 1'b1;
        end

        // result capture by software read or dma acknowledge
        if ((rd && address == OFS_DATA) || (st_ff.dma_req && dma_ack)) begin
            nxt_st.rvalid = 1'b0;
        end

        // ---------------------------------------------------------------
        // register writes
        // ---------------------------------------------------------------
        // calibration offsets take no write; start bits are not stored,
        // they only raise a pending flag that the idle phase consumes
        if (wr) begin
            unique case (address)
                OFS_CTRL: begin
                    nxt_st.en       = writedata[C_EN];
                    nxt_st.scan     = writedata[C_SCAN];
                    nxt_st.rtrig_en = writedata[C_RTRIG];
                    nxt_st.jtrig_en = writedata[C_JTRIG];
                    nxt_st.awd_en   = writedata[C_AWD];
                    nxt_st.awd_mode = writedata[C_AWDM+1:C_AWDM];
                    nxt_st.dma_en   = writedata[C_DMA];
                    if (writedata[C_START]) begin
                        nxt_st.rpend = 1'b1;
                    end
                    if (writedata[C_JSTART]) begin
                        nxt_st.jpend = 1'b1;
                    end
                end
                OFS_CHSEL: begin
                    nxt_st.sgl_ch = writedata[CH_W-1:0];
                    nxt_st.inj_ch = writedata[CHS_INJ+CH_W-1:CHS_INJ];
                end
                OFS_SCAN:  nxt_st.scan_mask = writedata[NUM_CH-1:0];
                OFS_AWDCH: nxt_st.awd_ch    = writedata[CH_W-1:0];
                OFS_AWDMK: nxt_st.awd_mask  = writedata[NUM_CH-1:0];
                OFS_THR: begin
                    nxt_st.thr_lo = writedata[RES_W-1:0];
                    nxt_st.thr_hi = writedata[THR_HI+RES_W-1:THR_HI];
                end
                OFS_STAT:  ev_clr        = writedata[NUM_EV-1:0];
                OFS_IEN:   nxt_st.ien    = writedata[NUM_EV-1:0];
                default: ;
            endcase
        end

        // ---------------------------------------------------------------
        // timer triggers
        // ---------------------------------------------------------------
        // a trigger that lands while busy merges into the pending flag
        if (reg_trig && st_ff.rtrig_en) begin
            nxt_st.rpend = 1'b1;
        end
        if (inj_trig && st_ff.jtrig_en) begin
            nxt_st.jpend = 1'b1;
        end

        // ---------------------------------------------------------------
        // conversion phases
        // ---------------------------------------------------------------
        unique case (st_ff.phase)
            PH_IDLE: begin
                // injected requests go first; regular ones wait for capture
                if (nxt_st.en && nxt_st.jpend) begin
                    nxt_st.jpend   = 1'b0;
                    nxt_st.cur_inj = 1'b1;
                    nxt_st.ana.ch  = st_ff.inj_ch;
                    nxt_st.phase   = PH_SAMPLE;
                end else if (nxt_st.en && !nxt_st.rvalid && st_ff.scan_act) begin
                    nxt_st.cur_inj = 1'b0;
                    nxt_st.ana.ch  = st_ff.sch;
                    nxt_st.phase   = PH_SAMPLE;
                end else if (nxt_st.en && !nxt_st.rvalid && nxt_st.rpend) begin
                    nxt_st.rpend   = 1'b0;
                    nxt_st.cur_inj = 1'b0;
                    nc = next_ch(st_ff.scan_mask, '0, 1'b1);
                    // mode taken from this cycle's write, so scan and start may share one write
                    if (!nxt_st.scan) begin
                        nxt_st.ana.ch = st_ff.sgl_ch;
                        nxt_st.phase  = PH_SAMPLE;
                    end else if (nc[CH_W]) begin
                        nxt_st.ana.ch   = nc[CH_W-1:0];
                        nxt_st.scan_act = 1'b1;
                        nxt_st.phase    = PH_SAMPLE;
                    end
                end
                nxt_st.cnt = '0;
            end
            PH_SAMPLE: begin
                // switch stays closed for the whole sample time so the hold node settles
                if (st_ff.cnt == BIT_W'(SAMPLE_CYC - 1)) begin
                    nxt_st.phase     = PH_CONV;
                    nxt_st.cnt       = MSB_IDX;
                    nxt_st.ana.trial = RES_W'(1) << MSB_IDX;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                end
            end
            PH_CONV: begin
                // keep the trial bit only if the input sits at or above it
                // cnt walks from the msb down to bit zero, one decision per cycle
                res = st_ff.ana.trial;
                res[st_ff.cnt] = cmp_above;
                if (st_ff.cnt != '0) begin
                    res[st_ff.cnt - 1'b1] = 1'b1;
                    nxt_st.ana.trial = res;
                    nxt_st.cnt       = st_ff.cnt - 1'b1;
                end else begin
                    nxt_st.phase     = PH_IDLE;
                    nxt_st.ana.trial = '0;
                    if (st_ff.cur_inj) begin
                        nxt_st.jdata   = res;
                        ev_set[S_JEOC] = 1'b1;
                    end else begin
                        nxt_st.rdata   = res;
                        nxt_st.rch     = st_ff.ana.ch;
                        nxt_st.rvalid  = 1'b1;
                        ev_set[S_EOC]  = 1'b1;
                        if (st_ff.scan_act) begin
                            nc = next_ch(st_ff.scan_mask, st_ff.ana.ch, 1'b0);
                            nxt_st.sch      = nc[CH_W-1:0];
                            nxt_st.scan_act = nc[CH_W];
                        end
                    end
                    // codes above the last channel are never watched
                    if (st_ff.awd_en
                        && st_ff.ana.ch < CH_W'(NUM_CH)
                        && watched[st_ff.ana.ch]
                        && (res > st_ff.thr_hi || res < st_ff.thr_lo)) begin
                        ev_set[S_AWD] = 1'b1;
                    end
                end
            end
            default: nxt_st.phase = PH_IDLE;
        endcase

        // ---------------------------------------------------------------
        // disable
        // ---------------------------------------------------------------
        // disabling aborts any conversion and drops pending work
        if (!nxt_st.en) begin
            nxt_st.phase     = PH_IDLE;
            nxt_st.scan_act  = 1'b0;
            nxt_st.rpend     = 1'b0;
            nxt_st.jpend     = 1'b0;
            nxt_st.ana.trial = '0;
        end

        // ---------------------------------------------------------------
        // analog routing and events
        // ---------------------------------------------------------------
        // analog routing follows the channel under conversion; internal
        // sources stay off in idle so they draw nothing between conversions
        nxt_st.ana.sample     = (nxt_st.phase == PH_SAMPLE);
        nxt_st.ana.temp_en    = (nxt_st.phase != PH_IDLE) && nxt_st.ana.ch == CH_TEMP;
        nxt_st.ana.bgap_en    = (nxt_st.phase != PH_IDLE) && nxt_st.ana.ch == CH_VREF;
        nxt_st.ana.bat_div_en = (nxt_st.phase != PH_IDLE) && nxt_st.ana.ch == CH_VBAT;

        // sticky events: a set in the clearing cycle wins
        // irq and dma request come from next state so they move with status and data
        nxt_st.status  = (st_ff.status & ~ev_clr) | ev_set;
        nxt_st.irq     = |(nxt_st.status & nxt_st.ien);
        nxt_st.dma_req = nxt_st.rvalid && nxt_st.dma_en;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff         <= '0;
            st_ff.waitreq <= 1'b1;
            st_ff.phase   <= PH_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // every output is a field of the state register, no logic behind the flop
    assign readdata    = st_ff.rd;
    assign waitrequest = st_ff.waitreq;
    assign dma_req     = st_ff.dma_req;
    assign ana         = st_ff.ana;
    assign irq         = st_ff.irq;

endmodule : sar_adc_sequencer

`default_nettype wire

//--- sar_pkg.sv
// sar_pkg: constants, field layouts and carrier types of the sar converter sequencer
// assumes a 50 MHz peripheral clock and a word-aligned avalon-mm register window
package sar_pkg;

    // ---------------------------------------------------------------
    // converter geometry
    // ---------------------------------------------------------------
    localparam int         RES_W    = 12;
    localparam int         CH_W     = 5;
    localparam int         NUM_CH   = 19;
    localparam int         BIT_W    = 4;
    localparam logic [4:0] CH_TEMP  = 5'h10;
    localparam logic [4:0] CH_VREF  = 5'h11;
    localparam logic [4:0] CH_VBAT  = 5'h12;
    localparam logic [3:0] MSB_IDX  = 4'hB;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int         CLK_MHZ    = 50;
    localparam int         SAMPLE_NS  = 200;
    localparam int         SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam int         ADDR_W    = 6;
    localparam logic [5:0] OFS_CTRL  = 6'h00;
    localparam logic [5:0] OFS_CHSEL = 6'h04;
    localparam logic [5:0] OFS_SCAN  = 6'h08;
    localparam logic [5:0] OFS_AWDCH = 6'h0C;
    localparam logic [5:0] OFS_AWDMK = 6'h10;
    localparam logic [5:0] OFS_THR   = 6'h14;
    localparam logic [5:0] OFS_DATA  = 6'h18;
    localparam logic [5:0] OFS_JDATA = 6'h1C;
    localparam logic [5:0] OFS_STAT  = 6'h20;
    localparam logic [5:0] OFS_IEN   = 6'h24;
    localparam logic [5:0] OFS_CALTS = 6'h28;
    localparam logic [5:0] OFS_CALRF = 6'h2C;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int C_EN = 0, C_SCAN = 1, C_START = 2, C_RTRIG = 3;
    localparam int C_JTRIG = 4, C_JSTART = 5, C_AWD = 6, C_AWDM = 7;
    localparam int C_DMA = 9;
    localparam int CHS_INJ = 8, THR_HI = 16, DATA_CH = 16, ST_BUSY = 8;
    localparam int S_EOC = 0, S_JEOC = 1, S_AWD = 2, NUM_EV = 3;

    // watchdog scope
    localparam logic [1:0] AWD_ONE = 2'h0;
    localparam logic [1:0] AWD_SUB = 2'h1;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_CONV   = 2'b10
    } phase_t;

    // signals toward the analog front end
    typedef struct packed {
        logic [CH_W-1:0]  ch;
        logic             sample;
        logic [RES_W-1:0] trial;
        logic             temp_en;
        logic             bgap_en;
        logic             bat_div_en;
    } ana_t;

    typedef struct packed {
        logic              en, scan, rtrig_en, jtrig_en, awd_en, dma_en;
        logic [1:0]        awd_mode;
        logic [CH_W-1:0]   sgl_ch, inj_ch, awd_ch, sch;
        logic [NUM_CH-1:0] scan_mask, awd_mask;
        logic [RES_W-1:0]  thr_lo, thr_hi, rdata, jdata;
        logic [CH_W-1:0]   rch;
        logic              rvalid, rpend, jpend, scan_act, cur_inj;
        logic [NUM_EV-1:0] status, ien;
        phase_t            phase;
        logic [BIT_W-1:0]  cnt;
        ana_t              ana;
        logic              dma_req, irq, waitreq;
        logic [31:0]       rd;
    } regs_t;

endpackage : sar_pkg

//--- sar_front_model.sv
// sar_front_model: analog sources and comparator in front of the sequencer
// assumes the comparator answers in the same cycle as the trial code
`timescale 1ns/1ps
`default_nettype none

module sar_front_model
    import sar_pkg::*;
(
    // analog levels per channel
    input  wire logic [RES_W-1:0] vin [NUM_CH],
    // converter side
    input  wire ana_t             ana,
    output var  logic             cmp_above
);
    logic [RES_W-1:0] lvl;

    // internal sources give a wrong level unless their enable is on
    always_comb begin
        case (ana.ch)
            CH_TEMP: lvl = ana.temp_en ? vin[CH_TEMP] : ~vin[CH_TEMP];
            CH_VREF: lvl = ana.bgap_en ? vin[CH_VREF] : ~vin[CH_VREF];
            CH_VBAT: lvl = ana.bat_div_en ? vin[CH_VBAT] >> 1 : vin[CH_VBAT];
            default: lvl = (ana.ch < 5'h13) ? vin[ana.ch] : '0;
        endcase
    end

    assign cmp_above = (lvl >= ana.trial);
endmodule : sar_front_model
`default_nettype wire

//--- sar_adc_sequencer_sva.sv
// sar_seq_checker: port-level assertions for the converter sequencer
// assumes one clock domain and bind onto sar_adc_sequencer
`timescale 1ns/1ps
`default_nettype none

module sar_seq_checker
    import sar_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       writedata,
    input wire logic [31:0]       readdata,
    input wire logic              waitrequest,
    input wire logic              reg_trig,
    input wire logic              inj_trig,
    input wire logic              dma_req,
    input wire logic              dma_ack,
    input wire ana_t              ana,
    input wire logic              cmp_above,
    input wire logic              irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered next cycle");
    no_spurious_a: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("waitrequest dropped without a request");
    temp_route_a: assert property (ana.temp_en |-> ana.ch == CH_TEMP)
        else $error("sensor enable on a wrong channel");
    bgap_route_a: assert property (ana.bgap_en |-> ana.ch == CH_VREF)
        else $error("reference enable on a wrong channel");
    bat_route_a: assert property (ana.bat_div_en |-> ana.ch == CH_VBAT)
        else $error("divider enable on a wrong channel");
    sample_hold_a: assert property ($rose(ana.sample) |-> ana.sample[*8])
        else $error("sample phase too short");
    first_trial_a: assert property ($fell(ana.sample) && !$past(write) |-> ana.trial == 12'h800)
        else $error("first trial code is not midscale");
    ch_hold_a: assert property (ana.sample && $past(ana.sample) |-> $stable(ana.ch))
        else $error("channel changed while sampling");
    dma_clear_a: assert property (dma_ack && dma_req |=> !dma_req)
        else $error("dma request not withdrawn after ack");

    cover property ($rose(irq));
    cover property (dma_ack && dma_req);
    cover property ($rose(ana.bat_div_en));
endmodule : sar_seq_checker

bind sar_adc_sequencer sar_seq_checker u_chk (.ref_clk, .reset, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .reg_trig, .inj_trig, .dma_req, .dma_ack, .ana, .cmp_above, .irq);
`default_nettype wire

//--- sar_adc_sequencer_tb.sv
// sar_adc_sequencer_tb: register-driven tests of the converter sequencer
// assumes the front-end model answers the comparator; the bench plays timers and dma
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_tb;
    import sar_pkg::*;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [31:0]       writedata = '0;
    logic [31:0]       readdata, rd;
    logic              waitrequest, dma_req, cmp_above, irq;
    logic              reg_trig = 1'b0;
    logic              inj_trig = 1'b0;
    logic              dma_ack = 1'b0;
    ana_t              ana;
    logic [RES_W-1:0]  vin [NUM_CH];
    int                bad_count = 0;
    int                compares = 0;
    int                cyc = 0;
    int                wch [6] = '{10, 0, 0, 16, 5, 16};
    int                wmd [6] = '{0, 0, 1, 1, 2, 2};
    int                wexp [6] = '{1, 0, 1, 0, 0, 1};

    sar_adc_sequencer #(.CAL_TS_VAL(12'h3C1), .CAL_REF_VAL(12'h2D7)) u_dut (.ref_clk, .reset, .address,
        .read, .write, .writedata, .readdata, .waitrequest, .reg_trig, .inj_trig, .dma_req, .dma_ack,
        .ana, .cmp_above, .irq);
    sar_front_model u_afe (.vin, .ana, .cmp_above);

    always #10 ref_clk = ~ref_clk;

    // cuts a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one avalon access; an extra edge after release keeps strobes from being reassigned
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [5:0] a, input string nm, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdc

    task automatic wait_st(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
        chk("status_flag", 32'(rd[b]), 32'h1);
    endtask : wait_st

    task automatic wait_dma();
        int n;
        n = 0;
        while (dma_req !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        chk("dma_req", 32'(dma_req), 32'h1);
    endtask : wait_dma

    task automatic irq_is(input logic e);
        @(posedge ref_clk);
        chk("irq", 32'(irq), 32'(e));
    endtask : irq_is

    // expected data word: channel above, code below; the battery reads halved
    function automatic logic [31:0] res(input int c);
        res = {11'h0, c[4:0], 4'h0, (c == 18) ? vin[18] >> 1 : vin[c]};
    endfunction : res

    initial begin
        for (int i = 0; i < 16; i++) begin
            vin[i] = 12'h0A0 * i + 12'h021;
        end
        vin[16] = 12'h7A3;
        vin[17] = 12'h5F0;
        vin[18] = 12'hC84;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rdc(OFS_CTRL, "ctrl_reset", 32'h0);
        rdc(OFS_STAT, "status_reset", 32'h0);
        wr(OFS_CALTS, 32'hFFFFFFFF);
        wr(OFS_CALRF, 32'h0);
        rdc(OFS_CALTS, "cal_sensor", 32'h3C1);
        rdc(OFS_CALRF, "cal_reference", 32'h2D7);
        rdc(6'h30, "unmapped", 32'h0);
        // single shot on every channel
        for (int c = 0; c < NUM_CH; c++) begin
            wr(OFS_CHSEL, 32'(c));
            wr(OFS_CTRL, 32'h5);
            wait_st(S_EOC);
            rdc(OFS_DATA, "single_data", res(c));
            wr(OFS_STAT, 32'h1);
        end
        // timer triggers: regular on channel 3, injected on channel 17
        wr(OFS_CHSEL, 32'h1103);
        wr(OFS_CTRL, 32'h19);
        reg_trig <= 1'b1;
        @(posedge ref_clk);
        reg_trig <= 1'b0;
        wait_st(S_EOC);
        rdc(OFS_DATA, "trig_data", res(3));
        inj_trig <= 1'b1;
        @(posedge ref_clk);
        inj_trig <= 1'b0;
        wait_st(S_JEOC);
        bus(1'b0, OFS_JDATA, 32'h0);
        chk("inj_data", rd & 32'hFFF, 32'(vin[17]));
        wr(OFS_STAT, 32'h7);
        // scan of 1, 5, 17 with dma; a stalled capture must not be overwritten
        wr(OFS_SCAN, 32'h20022);
        wr(OFS_CTRL, 32'h207);
        wait_dma();
        repeat (40) @(posedge ref_clk);
        rdc(OFS_DATA, "scan_first", res(1));
        wait_dma();
        dma_ack <= 1'b1;
        @(posedge ref_clk);
        dma_ack <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("dma_drop", 32'(dma_req), 32'h0);
        wait_dma();
        rdc(OFS_DATA, "scan_last", res(17));
        wr(OFS_CTRL, 32'h1);
        wr(OFS_STAT, 32'h7);
        // watchdog scopes: one channel 10, subset {0}, all
        wr(OFS_THR, 32'h06000200);
        wr(OFS_IEN, 32'h4);
        wr(OFS_AWDCH, 32'hA);
        wr(OFS_AWDMK, 32'h1);
        for (int k = 0; k < 6; k++) begin
            wr(OFS_CHSEL, 32'(wch[k]));
            wr(OFS_CTRL, 32'h45 | (32'(wmd[k]) << 7));
            wait_st(S_EOC);
            rdc(OFS_DATA, "awd_data", res(wch[k]));
            bus(1'b0, OFS_STAT, 32'h0);
            chk("awd_flag", 32'(rd[S_AWD]), 32'(wexp[k]));
            chk("awd_irq", 32'(irq), 32'(wexp[k]));
            if (k < 5) begin
                wr(OFS_STAT, 32'h7);
            end
        end
        wr(OFS_IEN, 32'h0);
        irq_is(1'b0);
        wr(OFS_IEN, 32'h4);
        irq_is(1'b1);
        wr(OFS_STAT, 32'h4);
        irq_is(1'b0);
        rdc(OFS_STAT, "status_cleared", 32'h1);
        close_out();
    end
endmodule : sar_adc_sequencer_tb
`default_nettype wire
